/* File: logic/reset_config_word_upper_decode.sv */
`default_nettype none
module reset_config_word_upper_decode #(
	parameter int N_CORES = rcw_pkg::NUM_CORES,
	parameter int N_PERIPH = rcw_pkg::NUM_PERIPH,
	parameter int TIMEOUT = rcw_pkg::CFG_TIMEOUT_CYCLES
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic power_on_reset_n_i,
	input wire logic hard_reset_n_i,
	input wire logic soft_reset_n_i,
	input wire logic wide_data_strap_i,
	input wire logic [1:0] clock_mode_straps_i,
	input wire logic cfg_wr_i,
	input wire logic [rcw_pkg::WORD_W-1:0] cfg_word_i,
	input wire logic clock_output_disable_i,
	input wire logic [N_PERIPH-1:0] periph_stop_i,
	input wire logic skew_elim_mode_i,
	input wire logic [N_CORES-1:0] core_stop_req_i,
	input wire logic [N_CORES-1:0] core_wait_req_i,
	input wire logic [N_CORES-1:0] core_irq_i,
	input wire logic [N_CORES-1:0] core_debug_req_i,
	output logic device_in_reset_o,
	output logic bus_busy_disable_sel_o,
	output logic request_mask_sel_o,
	output logic eth_on_data_bus_o,
	output logic eth_on_gpio_o,
	output logic transfer_type_pin_sel_o,
	output logic chip_sel5_pin_sel_o,
	output logic [1:0] transfer_code_pin_sel_o,
	output logic bank_select_active_o,
	output logic host_little_endian_sel_o,
	output logic munged_endian_sel_o,
	output logic [rcw_pkg::CLOCK_MODE_W-1:0] clock_mode_bits_o,
	output logic pll_mult_valid_o,
	output logic cfg_from_bus_o,
	output logic cfg_reserved_err_o,
	output logic bus_clock_en_o,
	output logic [N_PERIPH-1:0] periph_clk_en_o,
	output logic ref_from_input_pin_o,
	output logic [N_CORES-1:0] core_waiting_o,
	output logic [N_CORES-1:0] core_stopped_o
);
	import rcw_pkg::*;

	typedef struct packed {
		logic por_s1;
		logic por_s2;
		logic por_d;
		logic hr_s1;
		logic hr_s2;
		logic sr_s1;
		logic sr_s2;
		logic [2:0] strap_s1;
		logic [2:0] strap_s2;
		logic [1:0] strap_low;
		logic wide_strap;
		logic por_pending;
		phase_t phase;
		logic start;
		logic [WORD_W-1:0] word;
		logic in_reset;
		dec_t dec;
		logic [CLOCK_MODE_W-1:0] pll_mode;
		logic pll_valid;
		logic from_bus;
		logic rsv_err;
		logic bus_clk_en;
		logic [N_PERIPH-1:0] periph_en;
		logic ref_input;
		logic [N_CORES-1:0] core_wait;
		logic [N_CORES-1:0] core_stop;
	} top_state_t;

	top_state_t st;
	top_state_t next_st;
	logic por_rise;
	logic dev_reset;

	cfg_if cfg ();

	////////////////////////////////////////////////////////////////////////////////
	// word capture window
	cfg_loader #(
		.TIMEOUT(TIMEOUT)
	) u_loader (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.cfg_wr_i(cfg_wr_i),
		.cfg_word_i(cfg_word_i),
		.lp(cfg.loader)
	);

	assign cfg.start = st.start;

	// events seen on the synchronised pins
	assign por_rise = st.por_s2 & ~st.por_d;
	assign dev_reset = ~st.por_s2 | ~st.hr_s2 | ~st.sr_s2;

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		next_st = st;
		next_st.start = 1'h0;

		// two-stage synchronisers for pins; the first stage feeds only the second
		next_st.por_s1 = power_on_reset_n_i;
		next_st.por_s2 = st.por_s1;
		next_st.por_d = st.por_s2;
		next_st.hr_s1 = hard_reset_n_i;
		next_st.hr_s2 = st.hr_s1;
		next_st.sr_s1 = soft_reset_n_i;
		next_st.sr_s2 = st.sr_s1;
		next_st.strap_s1 = {wide_data_strap_i, clock_mode_straps_i};
		next_st.strap_s2 = st.strap_s1;

		// straps are caught as power-on releases with hard reset still low
		if (por_rise && !st.hr_s2)
		begin
			next_st.strap_low = st.strap_s2[1:0];
			next_st.wide_strap = st.strap_s2[2];
			next_st.por_pending = 1'h1;
		end

		// reset sequencing
		case (st.phase)
			PH_RUN:
			begin
				if (!st.hr_s2)
				begin
					next_st.in_reset = 1'h1;
					if (st.por_s2)
					begin
						next_st.start = 1'h1;
						next_st.phase = PH_CFG;
					end
				end
			end
			PH_CFG:
			begin
				if (!st.por_s2)
				begin
					next_st.phase = PH_RUN;
				end
				else if (cfg.done)
				begin
					next_st.word = cfg.word;
					next_st.from_bus = cfg.from_bus;
					next_st.rsv_err = ~reserved_ok(cfg.word);
					if (st.por_pending)
					begin
						next_st.pll_mode = {clock_mode_high(cfg.word), st.strap_low};
						next_st.pll_valid = 1'h1;
						next_st.por_pending = 1'h0;
					end
					next_st.phase = PH_HOLD;
				end
			end
			PH_HOLD:
			begin
				if (!st.por_s2)
				begin
					next_st.phase = PH_RUN;
				end
				else if (st.hr_s2)
				begin
					// decoded fields change only here, once per reset
					next_st.dec = decode_word(st.word, st.wide_strap);
					next_st.in_reset = 1'h0;
					next_st.phase = PH_RUN;
				end
			end
			default:
			begin
				next_st.phase = PH_RUN;
			end
		endcase

		// clock controls
		next_st.bus_clk_en = ~clock_output_disable_i;
		next_st.periph_en = ~periph_stop_i;
		next_st.ref_input = skew_elim_mode_i;

		// core low-power modes
		for (int i = 0; i < N_CORES; i++)
		begin
			if (dev_reset)
			begin
				next_st.core_stop[i] = 1'h0;
				next_st.core_wait[i] = 1'h0;
			end
			else if (st.core_stop[i])
			begin
				next_st.core_stop[i] = 1'h1;
			end
			else if (st.core_wait[i])
			begin
				next_st.core_wait[i] = ~(core_irq_i[i] | core_debug_req_i[i]);
			end
			else if (core_stop_req_i[i])
			begin
				next_st.core_stop[i] = 1'h1;
			end
			else if (core_wait_req_i[i])
			begin
				next_st.core_wait[i] = 1'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			st <= '0;
			st.in_reset <= 1'h1;
			st.word <= DEFAULT_WORD;
			st.dec <= DEC_RESET;
			st.pll_mode <= CLOCK_MODE_RESET;
			st.strap_low <= STRAP_RESET;
			st.phase <= PH_RUN;
			st.bus_clk_en <= 1'h1;
			st.periph_en <= '1;
		end
		else
		begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from the state register
	assign device_in_reset_o = st.in_reset;
	assign bus_busy_disable_sel_o = st.dec.bus_busy_disable_sel;
	assign request_mask_sel_o = st.dec.request_mask_sel;
	assign eth_on_data_bus_o = st.dec.eth_on_data_bus;
	assign eth_on_gpio_o = st.dec.eth_on_gpio;
	assign transfer_type_pin_sel_o = st.dec.transfer_type_pin_sel;
	assign chip_sel5_pin_sel_o = st.dec.chip_sel5_pin_sel;
	assign transfer_code_pin_sel_o = st.dec.transfer_code_pin_sel;
	assign bank_select_active_o = st.dec.bank_select_active;
	assign host_little_endian_sel_o = st.dec.host_little_endian_sel;
	assign munged_endian_sel_o = st.dec.munged_endian_sel;
	assign clock_mode_bits_o = st.pll_mode;
	assign pll_mult_valid_o = st.pll_valid;
	assign cfg_from_bus_o = st.from_bus;
	assign cfg_reserved_err_o = st.rsv_err;
	assign bus_clock_en_o = st.bus_clk_en;
	assign periph_clk_en_o = st.periph_en;
	assign ref_from_input_pin_o = st.ref_input;
	assign core_waiting_o = st.core_wait;
	assign core_stopped_o = st.core_stop;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	logic apply;
	assign apply = (st.phase == PH_HOLD) && st.por_s2 && st.hr_s2;

	strap_capture_a: assert property (
		(por_rise && !st.hr_s2) |=> (st.strap_low == $past(st.strap_s2[1:0]) && st.por_pending))
		else $error("clock-mode straps not captured at power-on release");

	pll_hold_a: assert property (
		(st.pll_valid && !st.por_pending) |=> (st.por_pending || $stable(st.pll_mode)))
		else $error("pll multiplier changed on a later hard reset");

	clock_mode_join_a: assert property (
		(st.phase == PH_CFG && st.por_s2 && cfg.done && st.por_pending)
		|=> (st.pll_mode == {clock_mode_high($past(cfg.word)), $past(st.strap_low)}))
		else $error("clock-mode bits wrongly joined");

	bus_busy_decode_a: assert property (
		apply |=> (bus_busy_disable_sel_o == st.word[BUS_BUSY_BIT] && !device_in_reset_o))
		else $error("bus-busy select not taken from the word");

	eth_route_a: assert property (
		apply |=> (eth_on_data_bus_o == (st.word[ETH_ROUTE_BIT] && !st.wide_strap)
			&& eth_on_gpio_o == !st.word[ETH_ROUTE_BIT]))
		else $error("ethernet route decoded wrongly");

	tcode_decode_a: assert property (
		apply |=> (bank_select_active_o ==
			({st.word[TCODE_FIRST_BIT], st.word[TCODE_LAST_BIT]} == TCODE_BANK_SEL)))
		else $error("transfer-code select decoded wrongly");

	endian_decode_a: assert property (
		munged_endian_sel_o |-> host_little_endian_sel_o)
		else $error("munged mode without little endian");

	fields_stable_a: assert property (
		!st.in_reset |=> (st.in_reset || $stable(st.dec)))
		else $error("decoded fields moved outside reset");

	stop_exit_a: assert property (
		(st.core_stop[0] && !dev_reset) |=> st.core_stop[0])
		else $error("core left stop without a device reset");

	wait_exit_a: assert property (
		(st.core_wait[0] && !dev_reset && (core_irq_i[0] || core_debug_req_i[0]))
		|=> !st.core_wait[0])
		else $error("core stayed in wait after a wake event");

	clock_out_mask_a: assert property (
		clock_output_disable_i [*2] |=> !bus_clock_en_o)
		else $error("bus clock output not masked");

	cover_por_run_c: cover property (por_rise ##[1:1000] apply);
	cover_bus_word_c: cover property (cfg.done && cfg.from_bus);
	cover_core_stop_c: cover property (st.core_stop[0] ##1 dev_reset);
	cover_second_hr_c: cover property (apply && st.pll_valid && !st.por_pending);

endmodule : reset_config_word_upper_decode
`default_nettype wire

/* File: shared/rcw_pkg.sv */
`default_nettype none
package rcw_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// configuration word layout, bit numbers as counted in the word
	localparam int WORD_W = 32;
	localparam int BUS_BUSY_BIT = 17;
	localparam int REQ_MASK_BIT = 18;
	localparam int ETH_ROUTE_BIT = 19;
	localparam int TTYPE_PIN_BIT = 20;
	localparam int CHIP_SEL5_BIT = 21;
	localparam int TCODE_FIRST_BIT = 22;
	localparam int TCODE_LAST_BIT = 23;
	localparam int LITTLE_END_BIT = 24;
	localparam int MUNGED_BIT = 25;
	localparam int RSV_ZERO_A_BIT = 26;
	localparam int RSV_ONE_BIT = 27;
	localparam int CLK_MODE_FIRST_BIT = 28;
	localparam int CLK_MODE_MID_BIT = 29;
	localparam int CLK_MODE_LAST_BIT = 30;
	localparam int RSV_ZERO_B_BIT = 31;

	////////////////////////////////////////////////////////////////////////////////
	// reset values and timing
	localparam logic [WORD_W-1:0] DEFAULT_WORD = 32'h0000_0000;
	localparam int CFG_TIMEOUT_CYCLES = 1024;
	localparam int CLOCK_MODE_W = 5;
	localparam logic [CLOCK_MODE_W-1:0] CLOCK_MODE_RESET = 5'h00;
	localparam logic [1:0] TCODE_BANK_SEL = 2'h2;
	localparam logic [1:0] STRAP_RESET = 2'h0;
	localparam int NUM_CORES = 4;
	localparam int NUM_PERIPH = 8;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {PH_RUN, PH_CFG, PH_HOLD} phase_t;

	typedef struct packed {
		logic bus_busy_disable_sel;
		logic request_mask_sel;
		logic eth_on_data_bus;
		logic eth_on_gpio;
		logic transfer_type_pin_sel;
		logic chip_sel5_pin_sel;
		logic [1:0] transfer_code_pin_sel;
		logic bank_select_active;
		logic host_little_endian_sel;
		logic munged_endian_sel;
	} dec_t;

	localparam dec_t DEC_RESET = '0;

	////////////////////////////////////////////////////////////////////////////////
	// multi-bit fields are read with the lower-numbered bit as msb
	function automatic logic [2:0] clock_mode_high(input logic [WORD_W-1:0] w);
		return {w[CLK_MODE_FIRST_BIT], w[CLK_MODE_MID_BIT], w[CLK_MODE_LAST_BIT]};
	endfunction : clock_mode_high

	function automatic logic reserved_ok(input logic [WORD_W-1:0] w);
		return w[RSV_ONE_BIT] & ~w[RSV_ZERO_A_BIT] & ~w[RSV_ZERO_B_BIT];
	endfunction : reserved_ok

	function automatic dec_t decode_word(input logic [WORD_W-1:0] w, input logic wide_strap);
		dec_t d;
		d.bus_busy_disable_sel = w[BUS_BUSY_BIT];
		d.request_mask_sel = w[REQ_MASK_BIT];
		d.eth_on_data_bus = w[ETH_ROUTE_BIT] & ~wide_strap;
		d.eth_on_gpio = ~w[ETH_ROUTE_BIT];
		d.transfer_type_pin_sel = w[TTYPE_PIN_BIT];
		d.chip_sel5_pin_sel = w[CHIP_SEL5_BIT];
		d.transfer_code_pin_sel = {w[TCODE_FIRST_BIT], w[TCODE_LAST_BIT]};
		d.bank_select_active = ({w[TCODE_FIRST_BIT], w[TCODE_LAST_BIT]} == TCODE_BANK_SEL);
		d.host_little_endian_sel = w[LITTLE_END_BIT];
		d.munged_endian_sel = w[LITTLE_END_BIT] & w[MUNGED_BIT];
		return d;
	endfunction : decode_word

endpackage : rcw_pkg
`default_nettype wire

/* File: shared/cfg_if.sv */
`default_nettype none
// carries the load request and the captured word between controller and loader
interface cfg_if;
	logic start;
	logic done;
	logic busy;
	logic from_bus;
	logic [rcw_pkg::WORD_W-1:0] word;

	modport loader (input start, output done, output busy, output from_bus, output word);
	modport ctrl (output start, input done, input busy, input from_bus, input word);
endinterface : cfg_if
`default_nettype wire

/* File: logic/cfg_loader.sv */
`default_nettype none
module cfg_loader #(
	parameter int TIMEOUT = rcw_pkg::CFG_TIMEOUT_CYCLES
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic cfg_wr_i,
	input wire logic [rcw_pkg::WORD_W-1:0] cfg_word_i,
	cfg_if.loader lp
);
	import rcw_pkg::*;

	localparam int CNT_W = $clog2(TIMEOUT + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT - 1);

	typedef struct packed {
		logic busy;
		logic done;
		logic from_bus;
		logic [CNT_W-1:0] cnt;
		logic [WORD_W-1:0] word;
	} ld_state_t;

	ld_state_t st;
	ld_state_t next_st;

	////////////////////////////////////////////////////////////////////////////////
	// window: take a bus write, or fall back to the default word on timeout
	always_comb
	begin
		next_st = st;
		next_st.done = 1'h0;
		if (lp.start)
		begin
			next_st.busy = 1'h1;
			next_st.cnt = '0;
		end
		else if (st.busy)
		begin
			if (cfg_wr_i)
			begin
				next_st.word = cfg_word_i;
				next_st.from_bus = 1'h1;
				next_st.done = 1'h1;
				next_st.busy = 1'h0;
			end
			else if (st.cnt == CNT_LAST)
			begin
				next_st.word = DEFAULT_WORD;
				next_st.from_bus = 1'h0;
				next_st.done = 1'h1;
				next_st.busy = 1'h0;
			end
			else
			begin
				next_st.cnt = st.cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			st <= '{busy: 1'h0, done: 1'h0, from_bus: 1'h0, cnt: '0, word: DEFAULT_WORD};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign lp.done = st.done;
	assign lp.busy = st.busy;
	assign lp.from_bus = st.from_bus;
	assign lp.word = st.word;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	timeout_default_a: assert property (
		(st.busy && !lp.start && !cfg_wr_i && st.cnt == CNT_LAST)
		|=> (st.done && !st.busy && st.word == DEFAULT_WORD && !st.from_bus))
		else $error("no default word after timeout");

	bus_word_take_a: assert property (
		(st.busy && !lp.start && cfg_wr_i)
		|=> (st.done && st.from_bus && st.word == $past(cfg_word_i)))
		else $error("bus word not taken");

	window_bound_a: assert property (
		st.busy |-> (st.cnt <= CNT_LAST))
		else $error("window counter ran past its limit");

	cover_timeout_c: cover property (st.busy && st.cnt == CNT_LAST && !cfg_wr_i);

endmodule : cfg_loader
`default_nettype wire

/* File: dv/rcw_source.sv */
`default_nettype none
// reset configuration word source: writes one word a set number of cycles after a request
module rcw_source
(
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [7:0] delay_i,
	input wire logic fix_i,
	input wire logic [rcw_pkg::WORD_W-1:0] word_i,
	output logic cfg_wr_o,
	output logic [rcw_pkg::WORD_W-1:0] cfg_word_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import rcw_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	logic armed = 1'b0;
	logic [7:0] left = 8'h00;
	logic [WORD_W-1:0] held = '0;

	initial cfg_wr_o = 1'b0;
	initial cfg_word_o = '0;

	// count down the requested delay, then pulse the strobe for one cycle
	always @(negedge clk_i)
	begin
		cfg_wr_o <= 1'b0;
		if (cfg_wr_o)
			cfg_word_o <= ~cfg_word_o; // released bus no longer shows the word
		if (go_i)
		begin
			armed <= 1'b1;
			left <= delay_i;
			if (fix_i)
				held <= (word_i | 32'h0800_0000) & 32'h7bff_ffff;
			else
				held <= word_i;
		end
		else if (armed && left == 8'h00)
		begin
			armed <= 1'b0;
			cfg_wr_o <= 1'b1;
			cfg_word_o <= held;
		end
		else if (armed)
			left <= left - 8'h01;
	end
endmodule : rcw_source
`default_nettype wire

/* File: dv/reset_config_word_upper_decode_bench.sv */
`default_nettype none
module reset_config_word_upper_decode_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import rcw_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// stimulus and observed signals
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic por_n = 1'b0;
	logic hard_n = 1'b0;
	logic soft_n = 1'b1;
	logic wide = 1'b0;
	logic [1:0] straps = 2'h0;
	logic cod = 1'b0;
	logic skew = 1'b0;
	logic [7:0] pstop = 8'h00;
	logic [3:0] stop_req = 4'h0;
	logic [3:0] wait_req = 4'h0;
	logic [3:0] irq = 4'h0;
	logic [3:0] dbg = 4'h0;
	logic go = 1'b0;
	logic fix = 1'b1;
	logic [7:0] dly = 8'h00;
	logic [WORD_W-1:0] src_word = '0;
	wire logic cfg_wr;
	wire logic [WORD_W-1:0] cfg_word;
	wire logic in_rst;
	wire logic [11:0] dec;
	wire logic [4:0] cm;
	wire logic pll_ok;
	wire logic from_bus;
	wire logic rsv_err;
	wire logic bclk;
	wire logic ref_pin;
	wire logic [7:0] pclk;
	wire logic [3:0] waiting;
	wire logic [3:0] stopped;
	wire logic [19:0] seen_v;
	logic [19:0] boot_q[$];
	logic [9:0] misc_q[$];
	logic [19:0] last_e = '0;
	logic [4:0] cm_exp = 5'h00;
	logic wide_cap = 1'b0;
	logic dir_q = 1'b1;
	logic [31:0] seed = 32'h0000_e6be;
	int fail_count = 0;
	int total_checks = 0;

	assign seen_v = {dec, cm, pll_ok, from_bus, rsv_err};

	// 20 MHz clock
	always #25 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////////////
	reset_config_word_upper_decode #(.TIMEOUT(16)) i_dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .power_on_reset_n_i(por_n),
		.hard_reset_n_i(hard_n), .soft_reset_n_i(soft_n), .wide_data_strap_i(wide),
		.clock_mode_straps_i(straps), .cfg_wr_i(cfg_wr), .cfg_word_i(cfg_word),
		.clock_output_disable_i(cod), .periph_stop_i(pstop), .skew_elim_mode_i(skew),
		.core_stop_req_i(stop_req), .core_wait_req_i(wait_req), .core_irq_i(irq),
		.core_debug_req_i(dbg), .device_in_reset_o(in_rst),
		.bus_busy_disable_sel_o(dec[11]), .request_mask_sel_o(dec[10]),
		.eth_on_data_bus_o(dec[9]), .eth_on_gpio_o(dec[8]),
		.transfer_type_pin_sel_o(dec[7]), .chip_sel5_pin_sel_o(dec[6]),
		.transfer_code_pin_sel_o(dec[5:4]), .bank_select_active_o(dec[3]),
		.host_little_endian_sel_o(dec[2]), .munged_endian_sel_o(dec[1]),
		.clock_mode_bits_o(cm), .pll_mult_valid_o(pll_ok), .cfg_from_bus_o(from_bus),
		.cfg_reserved_err_o(rsv_err), .bus_clock_en_o(bclk), .periph_clk_en_o(pclk),
		.ref_from_input_pin_o(ref_pin), .core_waiting_o(waiting), .core_stopped_o(stopped)
	);
	assign dec[0] = 1'b0;

	rcw_source i_src (
		.clk_i(clk_i), .go_i(go), .delay_i(dly), .fix_i(fix), .word_i(src_word),
		.cfg_wr_o(cfg_wr), .cfg_word_o(cfg_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// decoded outputs as the rules define them, lower bit number first in fields
	function automatic logic [19:0] expect_of(input logic [31:0] w, input logic acc);
		return {w[17], w[18], w[19] & ~wide_cap, ~w[19], w[20], w[21], w[22], w[23],
			w[22] & ~w[23], w[24], w[24] & w[25], 1'b0, cm_exp, 1'b1, acc,
			~(w[27] & ~w[26] & ~w[31])};
	endfunction : expect_of

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	// one reset sequence: power-on plus hard reset, or hard reset alone
	task automatic boot(input logic por, input logic [7:0] d, input logic f);
		logic [31:0] w;
		logic acc;
		int n;
		w = rnd();
		acc = !(por && d == 8'h00); // early write lands before the window opens
		@(negedge clk_i);
		hard_n <= 1'b0;
		if (por)
		begin
			por_n <= 1'b0;
			wide <= w[3];
			straps <= w[5:4];
		end
		repeat (4) @(negedge clk_i);
		por_n <= 1'b1;
		go <= 1'b1;
		dly <= d;
		fix <= f;
		src_word <= w;
		@(negedge clk_i);
		go <= 1'b0;
		if (f)
			w = (w | 32'h0800_0000) & 32'h7bff_ffff;
		if (!acc)
			w = 32'h0000_0000;
		if (por)
		begin
			wide_cap = wide;
			cm_exp = {w[28], w[29], w[30], straps};
			wide <= ~wide; // late strap changes must be ignored
			straps <= ~straps;
		end
		repeat (28) @(negedge clk_i);
		check(in_rst, 1'b1);
		last_e = expect_of(w, acc);
		boot_q.push_back(last_e);
		hard_n <= 1'b1;
		n = 0;
		while (in_rst !== 1'b0 && n < 20)
		begin
			@(negedge clk_i);
			n++;
		end
		check(n < 20, 1'b1);
		$display("boot test done: por=%0d delay=%0d", por, d);
	endtask : boot

	////////////////////////////////////////////////////////////////////////////////
	// compare decoded results when the reset sequence ends
	always @(negedge clk_i)
	begin
		if (dir_q === 1'b1 && in_rst === 1'b0)
		begin
			if (boot_q.size() == 0)
				check(1'b0, 1'b1);
			else
				check(seen_v, boot_q.pop_front());
		end
		dir_q = in_rst;
	end

	// clock gate outputs follow their controls one cycle late
	always @(posedge clk_i)
	begin
		if (misc_q.size() > 0)
		begin
			#1;
			check({bclk, pclk, ref_pin}, misc_q.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		logic [31:0] r;
		repeat (8) @(negedge clk_i);
		resetn_i <= 1'b1;
		boot(1'b1, 8'h05, 1'b1);
		boot(1'b0, 8'h09, 1'b1);
		boot(1'b1, 8'h00, 1'b1);
		boot(1'b0, 8'h00, 1'b0);
		boot(1'b1, 8'h09, 1'b0);
		boot(1'b0, 8'h05, 1'b1);
		// a write outside the window must change nothing
		go <= 1'b1;
		dly <= 8'h02;
		src_word <= rnd();
		@(negedge clk_i);
		go <= 1'b0;
		repeat (24)
		begin
			@(negedge clk_i);
			r = rnd();
			cod <= r[0];
			skew <= r[1];
			pstop <= r[15:8];
			misc_q.push_back({~r[0], ~r[15:8], r[1]});
		end
		repeat (2) @(negedge clk_i);
		check(seen_v, last_e);
		$display("clock gate test done");
		// core low-power modes
		stop_req <= 4'h1;
		wait_req <= 4'h6;
		@(negedge clk_i);
		stop_req <= 4'h0;
		wait_req <= 4'h0;
		check(stopped, 4'h1);
		check(waiting, 4'h6);
		irq <= 4'h3;
		@(negedge clk_i);
		irq <= 4'h0;
		check(stopped, 4'h1);
		check(waiting, 4'h4);
		dbg <= 4'h4;
		@(negedge clk_i);
		dbg <= 4'h0;
		check(waiting, 4'h0);
		soft_n <= 1'b0;
		repeat (5) @(negedge clk_i);
		check(stopped, 4'h0);
		soft_n <= 1'b1;
		$display("core mode test done");
		print_verdict();
	end

	// watchdog, far beyond the expected run of a few hundred cycles
	initial
	begin
		#100000;
		fail_count++;
		print_verdict();
	end
endmodule : reset_config_word_upper_decode_bench
`default_nettype wire
